// [logic/vphl_pkg.sv]
package vphl_pkg;
    // Command codes carried in the first byte of each frame
    localparam logic [7:0] CMD_VIDEO_ENABLE = 8'h01;
    localparam logic [7:0] CMD_VIDEO_DISABLE = 8'h02;
    localparam logic [7:0] CMD_STREAM_INFO = 8'h03;
    localparam logic [7:0] CMD_VIDEO_READ = 8'h04;
    localparam logic [7:0] CMD_AUDIO_START = 8'h05;
    localparam logic [7:0] CMD_AUDIO_STOP = 8'h06;
    // Status byte values returned by the info and video disable commands
    localparam logic [7:0] INFO_VALID = 8'hA5;
    localparam logic [7:0] INFO_NONE = 8'h00;
    localparam logic [7:0] STOPPED_ACK = 8'h5A;
    // Idle fill byte on the master-in line
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    // Sensor reset pulse length
    localparam int SENSOR_RST_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SENSOR_RST_CYC =
        (SENSOR_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        VPHL_IDLE,
        VPHL_ENABLED,
        VPHL_INFO_OK,
        VPHL_STREAM
    } vphl_mode_t;
endpackage

// [logic/vphl_spi_shift.sv]
`timescale 1ns/1ps
// Serial slave byte shifter, mode 0, MSB first, pins already synchronised
module vphl_spi_shift
    import vphl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Synchronised pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Byte side
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic frame_start,
    output logic frame_end
);
    logic sclk_d;
    logic cs_d;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic next_sclk_d;
    logic next_cs_d;
    logic [2:0] next_bit_cnt;
    logic [7:0] next_shreg;
    logic [7:0] next_txreg;
    logic [7:0] next_rx_byte;
    logic next_rx_valid;
    logic next_miso;

    // Edge detection and shifting
    always_comb begin
        next_sclk_d = sclk;
        next_cs_d = cs_n;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_txreg = txreg;
        next_rx_byte = rx_byte;
        next_rx_valid = 1'b0;
        next_miso = miso;
        if (cs_n) begin
            next_bit_cnt = 3'h0;
            next_txreg = tx_byte;
            next_miso = tx_byte[7];
        end else if (sclk && !sclk_d) begin
            next_shreg = {shreg[6:0], mosi};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
                next_rx_byte = {shreg[6:0], mosi};
                next_rx_valid = 1'b1;
            end
        end else if (!sclk && sclk_d) begin
            // Reload at byte boundary so the next byte leads with its MSB
            if (bit_cnt == 3'h0) begin
                next_txreg = {tx_byte[6:0], 1'b0};
                next_miso = tx_byte[7];
            end else begin
                next_txreg = {txreg[6:0], 1'b0};
                next_miso = txreg[7];
            end
        end
    end

    assign frame_start = cs_d && !cs_n;
    assign frame_end = !cs_d && cs_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            txreg <= 8'hFF;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            miso <= 1'b1;
        end else if (clk_en) begin
            sclk_d <= next_sclk_d;
            cs_d <= next_cs_d;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            txreg <= next_txreg;
            rx_byte <= next_rx_byte;
            rx_valid <= next_rx_valid;
            miso <= next_miso;
        end
    end
endmodule

// [logic/vphl_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - Processor raises its ready line when able to take or give a transfer.
// - Speaker amplifier enable is high exactly while audio streams.
// - Processor pulses the image sensor reset while bringing the sensor up.
// - Image data arrives from the sensor over the camera interface.
// - Enable, then stream info, then repeated video reads until stop.
module vphl_top
    import vphl_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int RST_CYC = SENSOR_RST_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Serial link from the host
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    // Handshake lines
    input wire logic host_sync,
    output logic proc_ready,
    // Image sensor side, already deserialised by the camera receiver
    input wire logic [DATA_W-1:0] pix_data,
    input wire logic pix_valid,
    output logic sensor_rst_n,
    // Audio
    output logic speaker_amp_enable,
    // Streaming state seen by the rest of the processor
    output logic video_on
);
    // Two-flop synchronisers for the serial, sync and valid pins; reset values match the
    // idle select, clock and valid levels so no false edge is seen after reset
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic cs_s;
    logic sclk_s;
    logic mosi_s;
    logic hsync_s;
    logic pv_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 5'h10;
            sync2 <= 5'h10;
        end else if (clk_en) begin
            sync1 <= {spi_cs_n, spi_sclk, spi_mosi, host_sync, pix_valid};
            sync2 <= sync1;
        end
    end
    assign cs_s = sync2[4];
    assign sclk_s = sync2[3];
    assign mosi_s = sync2[2];
    assign hsync_s = sync2[1];
    assign pv_s = sync2[0];

    // Pixel word register; the sensor data bus is quasi-static under valid
    // No freshness flag: a read repeats the last word if none has arrived
    logic [DATA_W-1:0] pix_hold;
    logic [DATA_W-1:0] next_pix_hold;
    logic pv_d;
    logic next_pv_d;

    // Streaming order state
    vphl_mode_t mode;
    vphl_mode_t next_mode;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic first_byte;
    logic next_first_byte;
    logic [7:0] tx_byte;
    logic [7:0] next_tx_byte;
    logic audio_on;
    logic next_audio_on;
    logic [15:0] rst_cnt;
    logic [15:0] next_rst_cnt;
    logic ready;
    logic next_ready;
    logic in_frame;
    logic next_in_frame;

    logic [7:0] rx_byte;
    logic rx_valid;
    logic frame_start;
    logic frame_end;

    vphl_spi_shift u_shift (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cs_n(cs_s),
        .sclk(sclk_s),
        .mosi(mosi_s),
        .miso(spi_miso),
        .tx_byte(tx_byte),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .frame_start(frame_start),
        .frame_end(frame_end)
    );

    // Pixel capture from the camera receiver on rising valid
    always_comb begin
        next_pv_d = pv_s;
        next_pix_hold = pix_hold;
        if (pv_s && !pv_d) begin
            next_pix_hold = pix_data;
        end
    end

    // Command decoding and streaming order
    always_comb begin
        next_mode = mode;
        next_cmd = cmd;
        next_first_byte = first_byte;
        next_tx_byte = tx_byte;
        next_audio_on = audio_on;
        next_in_frame = in_frame;
        // Sensor reset held low for a fixed time after reset release
        next_rst_cnt = rst_cnt;
        if (rst_cnt != 16'h0000) begin
            next_rst_cnt = rst_cnt - 16'h0001;
        end
        // New frame: expect a command byte, answer fill until decoded
        if (frame_start) begin
            next_first_byte = 1'b1;
            next_in_frame = 1'b1;
            next_tx_byte = FILL_BYTE;
        end
        // A cut frame drops its command so stray bytes do nothing
        if (frame_end) begin
            next_in_frame = 1'b0;
            next_cmd = 8'h00;
        end
        if (rx_valid && first_byte) begin
            next_first_byte = 1'b0;
            next_cmd = rx_byte;
            next_tx_byte = FILL_BYTE;
            // Out-of-order commands are ignored, not queued
            unique case (rx_byte)
                CMD_VIDEO_ENABLE: begin
                    if (mode == VPHL_IDLE) begin
                        next_mode = VPHL_ENABLED;
                    end
                end
                CMD_STREAM_INFO: begin
                    if (mode == VPHL_ENABLED) begin
                        next_mode = VPHL_INFO_OK;
                        next_tx_byte = INFO_VALID;
                    end else begin
                        next_tx_byte = INFO_NONE;
                    end
                end
                CMD_VIDEO_READ: begin
                    if (mode == VPHL_INFO_OK || mode == VPHL_STREAM) begin
                        next_mode = VPHL_STREAM;
                        next_tx_byte = pix_hold[7:0];
                    end
                end
                CMD_VIDEO_DISABLE: begin
                    next_mode = VPHL_IDLE;
                    next_tx_byte = STOPPED_ACK;
                end
                CMD_AUDIO_START: next_audio_on = 1'b1;
                CMD_AUDIO_STOP: next_audio_on = 1'b0;
                default: next_cmd = 8'h00;
            endcase
        end else if (rx_valid && cmd == CMD_VIDEO_READ &&
                     mode == VPHL_STREAM) begin
            // Each further byte returns the latest captured pixel word
            next_tx_byte = pix_hold[7:0];
        end
    end

    // Ready stays high outside frames once the sensor is up; inside a
    // frame it drops so a new one cannot begin until this one ends
    always_comb begin
        next_ready = (rst_cnt == 16'h0000) && !next_in_frame;
    end

    // State registers; clk_en low holds every one of them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= VPHL_IDLE;
            cmd <= 8'h00;
            first_byte <= 1'b0;
            tx_byte <= 8'hFF;
            audio_on <= 1'b0;
            rst_cnt <= 16'(RST_CYC);
            ready <= 1'b0;
            in_frame <= 1'b0;
            pix_hold <= '0;
            pv_d <= 1'b0;
        end else if (clk_en) begin
            mode <= next_mode;
            cmd <= next_cmd;
            first_byte <= next_first_byte;
            tx_byte <= next_tx_byte;
            audio_on <= next_audio_on;
            rst_cnt <= next_rst_cnt;
            ready <= next_ready;
            in_frame <= next_in_frame;
            pix_hold <= next_pix_hold;
            pv_d <= next_pv_d;
        end
    end

    // Outputs; hsync_s is observed but the host alone gates frame start
    assign proc_ready = ready;
    assign speaker_amp_enable = audio_on;
    assign sensor_rst_n = (rst_cnt == 16'h0000);
    assign video_on = (mode == VPHL_STREAM) && hsync_s;
endmodule

// [testbench/vphl_top_asserts.sv]
`timescale 1ns/1ps
// Port-level checker for the host link
module vphl_top_asserts
    import vphl_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int RST_CYC = SENSOR_RST_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Serial link
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    // Handshake
    input wire logic host_sync,
    input wire logic proc_ready,
    // Sensor, audio, state
    input wire logic [DATA_W-1:0] pix_data,
    input wire logic pix_valid,
    input wire logic sensor_rst_n,
    input wire logic speaker_amp_enable,
    input wire logic video_on
);
    default clocking @(posedge clk); endclocking
    // Checks pause while clk_en freezes the block
    default disable iff (!rst_n || !clk_en);

    logic [8:0] up;
    // Enabled cycles since reset release, saturating so it never wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up <= 9'h000;
        end else if (clk_en && up != 9'h1FF) begin
            up <= up + 9'h001;
        end
    end

    // Link idle long enough for the two-flop select path to settle
    sequence cs_quiet;
        spi_cs_n [*6];
    endsequence

    chk_sensor_held: assert property (up < RST_CYC - 1 |-> !sensor_rst_n)
        else $error("sensor reset released early");
    chk_sensor_freed: assert property (up > RST_CYC + 3 |-> sensor_rst_n)
        else $error("sensor reset held too long");
    chk_ready_gated: assert property (!sensor_rst_n |-> !proc_ready)
        else $error("ready while sensor in reset");
    chk_ready_drop: assert property ($fell(spi_cs_n) |-> ##[1:5] !proc_ready)
        else $error("ready stayed high in frame");
    chk_ready_busy: assert property (!spi_cs_n [*6] |-> !proc_ready)
        else $error("ready high mid frame");
    chk_ready_back: assert property (
        $rose(spi_cs_n) && sensor_rst_n |-> ##[1:6] proc_ready)
        else $error("ready did not return");
    chk_amp_quiet: assert property (
        cs_quiet |=> $stable(speaker_amp_enable))
        else $error("amp changed with link idle");
    chk_video_gate: assert property (!host_sync [*4] |=> !video_on)
        else $error("video on without host sync");
endmodule

bind vphl_top vphl_top_asserts #(.DATA_W(DATA_W), .RST_CYC(RST_CYC)) i_chk (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .host_sync(host_sync), .proc_ready(proc_ready), .pix_data(pix_data),
    .pix_valid(pix_valid), .sensor_rst_n(sensor_rst_n),
    .speaker_amp_enable(speaker_amp_enable), .video_on(video_on)
);

// [testbench/vphl_host_model.sv]
`timescale 1ns/1ps
// Serial master standing in for the host controller
module vphl_host_model
    import vphl_pkg::*;
(
    // Clock
    input wire logic clk,
    // Serial link
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    // Handshake
    output logic host_sync,
    input wire logic proc_ready
);
    localparam int HALF = 4; // Above the 3-cycle floor of the slave
    logic miso_s;

    // Idle link: select high, clock still, sync raised
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        host_sync = 1'b1;
    end

    // Sample a half cycle early so the registered line is settled
    always @(negedge clk) begin
        miso_s = spi_miso;
    end

    // Handshake level, changed by the caller just after a clock edge
    task automatic set_sync(input logic v);
        host_sync <= v;
    endtask

    // Command byte out, reply byte in, handed back at once
    task automatic frame(input logic [7:0] cmd, output logic [7:0] rep);
        logic [15:0] sh;
        int k;
        sh = {cmd, 8'h00};
        rep = 'x;
        for (k = 0; k < 2000; k++) begin
            @(negedge clk);
            if (proc_ready === 1'b1) break;
        end
        if (k == 2000) return;
        @(posedge clk);
        spi_cs_n <= 1'b0;
        spi_mosi <= sh[15];
        for (k = 0; k < 16; k++) begin
            repeat (HALF) @(posedge clk);
            spi_sclk <= 1'b1;
            if (k > 7) rep = {rep[6:0], miso_s};
            repeat (HALF) @(posedge clk);
            spi_sclk <= 1'b0;
            sh = sh << 1;
            spi_mosi <= sh[15];
        end
        repeat (HALF) @(posedge clk);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~sh[15]; // Released line must not keep its value
        repeat (HALF) @(posedge clk);
    endtask
endmodule

// [testbench/video_processor_host_link_tb_top.sv]
`timescale 1ns/1ps
module video_processor_host_link_tb_top;
    import vphl_pkg::*;
    localparam int RST = 4; // Short sensor reset keeps the run brief
    logic clk, rst_n, clk_en, pix_valid;
    logic [7:0] pix_data, r;
    logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, host_sync, proc_ready;
    logic sensor_rst_n, speaker_amp_enable, video_on;
    int n_mismatch = 0;
    int n_checks = 0;

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    vphl_top #(.DATA_W(8), .RST_CYC(RST)) i_dut (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .host_sync(host_sync), .proc_ready(proc_ready),
        .pix_data(pix_data), .pix_valid(pix_valid),
        .sensor_rst_n(sensor_rst_n),
        .speaker_amp_enable(speaker_amp_enable), .video_on(video_on));

    vphl_host_model i_host (
        .clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .host_sync(host_sync), .proc_ready(proc_ready));

    task automatic chk(input logic [7:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic chk_bit(input logic got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %b", $time, what, got);
        end
    endtask

    task automatic run(input logic [7:0] cmd, exp, input string what);
        logic [7:0] rep;
        i_host.frame(cmd, rep);
        chk(rep, exp, what);
    endtask

    // Reset with outputs checked inside and after it
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_bit(sensor_rst_n, 1'b0, "sensor rst");
        chk_bit(proc_ready, 1'b0, "ready in reset");
        chk_bit(speaker_amp_enable, 1'b0, "amp in reset");
        chk_bit(video_on, 1'b0, "video in reset");
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (RST + 12) @(negedge clk);
        chk_bit(sensor_rst_n, 1'b1, "sensor out");
        chk_bit(proc_ready, 1'b1, "ready up");
    endtask

    task automatic put_pix(input logic [7:0] v);
        @(posedge clk);
        pix_data <= v;
        pix_valid <= 1'b1;
        repeat (4) @(posedge clk);
        pix_valid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Refused out-of-order commands, then the full stream sequence
    task automatic t_stream;
        run(CMD_STREAM_INFO, INFO_NONE, "info early");
        run(CMD_VIDEO_READ, FILL_BYTE, "read early");
        run(8'hEE, FILL_BYTE, "unknown cmd");
        run(CMD_VIDEO_ENABLE, FILL_BYTE, "enable");
        run(CMD_STREAM_INFO, INFO_VALID, "info");
        put_pix(8'h3C);
        run(CMD_VIDEO_READ, 8'h3C, "read 1");
        put_pix(8'hC3);
        run(CMD_VIDEO_READ, 8'hC3, "read 2");
        @(negedge clk);
        chk_bit(video_on, 1'b1, "video on");
        @(posedge clk);
        i_host.set_sync(1'b0);
        repeat (6) @(negedge clk);
        chk_bit(video_on, 1'b0, "sync low");
        @(posedge clk);
        i_host.set_sync(1'b1);
        run(CMD_VIDEO_DISABLE, STOPPED_ACK, "stop ack");
        run(CMD_VIDEO_READ, FILL_BYTE, "read after stop");
        $display("test stream done");
    endtask

    // Amplifier follows audio start and stop, and a reset clears it
    task automatic t_audio;
        i_host.frame(CMD_AUDIO_START, r);
        @(negedge clk);
        chk_bit(speaker_amp_enable, 1'b1, "amp on");
        i_host.frame(CMD_AUDIO_STOP, r);
        @(negedge clk);
        chk_bit(speaker_amp_enable, 1'b0, "amp off");
        // A frame sent while frozen must leave no trace
        @(posedge clk);
        clk_en <= 1'b0;
        i_host.frame(CMD_AUDIO_START, r);
        @(negedge clk);
        chk_bit(speaker_amp_enable, 1'b0, "amp frozen");
        @(posedge clk);
        clk_en <= 1'b1;
        i_host.frame(CMD_AUDIO_START, r);
        @(negedge clk);
        chk_bit(speaker_amp_enable, 1'b1, "amp resumes");
        do_reset;
        chk_bit(speaker_amp_enable, 1'b0, "amp after reset");
        $display("test audio done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence; power-up wait before any frame
    initial begin
        clk_en = 1'b1;
        rst_n = 1'b0;
        pix_data = 8'h00;
        pix_valid = 1'b0;
        do_reset;
        $display("test reset done");
        t_stream;
        t_audio;
        tally_and_finish;
    end

    // Watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        $display("unexpected at %0t: watchdog", $time);
        tally_and_finish;
    end
endmodule
